//--- design/mpks_pkg.sv
// How it works
// [RL1] host holds key low 100ms, typ 500ms
// [RL2] status high no earlier than 15s
// [RL3] serial port ready after 13s
// [RL4] aux supply ready after 2.5s
// [RL5] bus port ready after 11s
// [RL6] key held grounded powers on automatically
// [RL7] host holds key low 2.5s to switch off
// [RL8] status low after 25s on power-off
// [RL9] serial port off after 14s
// [RL10] bus port off after 27s
// [RL11] power-on may follow power-off immediately
// [RL12] software shutdown command powers off
// [RL13] supply outside window powers off
// [RL14] temperature warning outside -30..80, off outside -40..85
// [RL15] detach and save before removing power
// [RL16] status high only when powered and ready
// [RL17] host drives reset low 100 to 500ms
// [RL18] reset only as emergency measure
// [RL19] supply warning and shutdown disabled at power-up
// [RL20] short key or reset pulses ignored
package mpks_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
   localparam int unsigned T_ON_MIN_MS = 100;
   localparam int unsigned T_ON_TYP_MS = 500;
   localparam int unsigned T_OFF_KEY_MS = 2500;
   localparam int unsigned T_ON_STATUS_MS = 16000;
   localparam int unsigned T_ON_UART_MS = 14000;
   localparam int unsigned T_ON_AUX_MS = 2500;
   localparam int unsigned T_ON_USB_MS = 12000;
   localparam int unsigned T_OFF_STATUS_MS = 26000;
   localparam int unsigned T_OFF_UART_MS = 15000;
   localparam int unsigned T_OFF_USB_MS = 28000;
   localparam int unsigned T_RST_MIN_MS = 100;
   localparam int unsigned T_RST_TYP_MS = 200;
   localparam int unsigned T_RST_MAX_MS = 500;
   localparam int unsigned T_DETACH_MS = 1000;
   localparam int signed TEMP_WARN_LO = -30;
   localparam int signed TEMP_WARN_HI = 80;
   localparam int signed TEMP_OFF_LO = -40;
   localparam int signed TEMP_OFF_HI = 85;
   localparam int unsigned MS_W = 16;
   localparam int unsigned SUB_W = 17;
   localparam int unsigned VOLT_W = 12;
   localparam int unsigned TEMP_W = 8;
   localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(CLK_PER_MS - 1);
endpackage : mpks_pkg

//--- design/mpks_if.sv
`timescale 1ns/100ps
interface mpks_if;
   logic pwr_key_n_o;
   logic pwr_key_n_oe_n;
   logic reset_n_o;
   logic reset_n_oe_n;
   logic status;
   logic uart_ready;
   logic usb_ready;
   logic aux_ready;
   modport device (input pwr_key_n_o, input pwr_key_n_oe_n, input reset_n_o, input reset_n_oe_n,
      output status, output uart_ready, output usb_ready, output aux_ready);
   modport host (output pwr_key_n_o, output pwr_key_n_oe_n, output reset_n_o, output reset_n_oe_n,
      input status, input uart_ready, input usb_ready, input aux_ready);
endinterface : mpks_if

//--- design/mpks_device.sv
`timescale 1ns/100ps
module mpks_device #(
   parameter int unsigned SCALE_MS = mpks_pkg::CLK_PER_MS
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   mpks_if.device bus,
   input wire logic i_sw_shutdown,
   input wire logic i_supply_window_en,
   input wire logic i_supply_warning_en,
   input wire logic i_cfg_valid,
   input wire logic [mpks_pkg::VOLT_W-1:0] i_volt,
   input wire logic [mpks_pkg::VOLT_W-1:0] i_volt_lo,
   input wire logic [mpks_pkg::VOLT_W-1:0] i_volt_hi,
   input wire logic signed [mpks_pkg::TEMP_W-1:0] i_temp,
   output logic o_supply_warning,
   output logic o_temp_warning,
   output logic o_fw_ready,
   output logic o_safe_state
);
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_BOOT = 3'b001,
      ST_ON = 3'b010,
      ST_DETACH = 3'b011,
      ST_DOWN = 3'b100
   } mpks_state_t;
   mpks_state_t st_r, st_nxt;
   logic [mpks_pkg::SUB_W-1:0] sub_r, sub_nxt;
   logic [mpks_pkg::MS_W-1:0] ms_r, ms_nxt;
   logic [mpks_pkg::MS_W-1:0] key_ms_r, key_ms_nxt;
   logic [mpks_pkg::MS_W-1:0] rst_ms_r, rst_ms_nxt;
   logic key_s1_r, key_s2_r, rst_s1_r, rst_s2_r;
   logic key_used_r, key_used_nxt;
   logic win_en_r, win_en_nxt, warn_en_r, warn_en_nxt;
   logic status_r, status_nxt, uart_r, uart_nxt, usb_r, usb_nxt, aux_r, aux_nxt;
   logic vwarn_r, vwarn_nxt, twarn_r, twarn_nxt;
   logic tick, key_low, rst_low, v_out, t_warn, t_off, rst_fire;
   logic key_on, key_off;
   always_ff @(posedge i_sys_clk) begin
      key_s1_r <= i_sys_rst ? 1'b1 : (bus.pwr_key_n_oe_n ? 1'b1 : bus.pwr_key_n_o);
      key_s2_r <= i_sys_rst ? 1'b1 : key_s1_r;
      rst_s1_r <= i_sys_rst ? 1'b1 : (bus.reset_n_oe_n ? 1'b1 : bus.reset_n_o);
      rst_s2_r <= i_sys_rst ? 1'b1 : rst_s1_r;
   end
   assign tick = (sub_r >= mpks_pkg::SUB_W'(SCALE_MS - 1));
   assign key_low = !key_s2_r;
   assign rst_low = !rst_s2_r;
   assign key_on = key_low && !key_used_r && (key_ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_ON_MIN_MS)); // RL1 RL20
   assign key_off = key_low && !key_used_r && (key_ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_OFF_KEY_MS)); // RL7 RL20
   assign rst_fire = !rst_low && (rst_ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_RST_MIN_MS)); // RL17 RL20
   assign v_out = win_en_r && ((i_volt < i_volt_lo) || (i_volt > i_volt_hi)); // RL13
   assign t_warn = ($signed(i_temp) < mpks_pkg::TEMP_W'(mpks_pkg::TEMP_WARN_LO))
      || ($signed(i_temp) > mpks_pkg::TEMP_W'(mpks_pkg::TEMP_WARN_HI)); // RL14
   assign t_off = ($signed(i_temp) < mpks_pkg::TEMP_W'(mpks_pkg::TEMP_OFF_LO))
      || ($signed(i_temp) > mpks_pkg::TEMP_W'(mpks_pkg::TEMP_OFF_HI)); // RL14
   always_comb begin
      sub_nxt = tick ? '0 : sub_r + 1'b1;
      key_ms_nxt = key_ms_r;
      rst_ms_nxt = rst_ms_r;
      key_used_nxt = key_used_r;
      if (!key_low) begin
         key_ms_nxt = '0;
         key_used_nxt = 1'b0;
      end else if (tick && key_ms_r != '1) begin
         key_ms_nxt = key_ms_r + 1'b1;
      end
      if (!rst_low) begin
         rst_ms_nxt = '0;
      end else if (tick && rst_ms_r != '1) begin
         rst_ms_nxt = rst_ms_r + 1'b1;
      end
      st_nxt = st_r;
      ms_nxt = (tick && ms_r != '1) ? ms_r + 1'b1 : ms_r;
      win_en_nxt = (i_cfg_valid && st_r != ST_OFF) ? i_supply_window_en : win_en_r;
      warn_en_nxt = (i_cfg_valid && st_r != ST_OFF) ? i_supply_warning_en : warn_en_r;
      status_nxt = status_r;
      uart_nxt = uart_r;
      usb_nxt = usb_r;
      aux_nxt = aux_r;
      unique case (st_r)
         ST_OFF: begin
            if (key_on) begin // RL6 RL11
               st_nxt = ST_BOOT;
               ms_nxt = '0;
               key_used_nxt = 1'b1;
               win_en_nxt = 1'b0; // RL19
               warn_en_nxt = 1'b0; // RL19
            end
         end
         ST_BOOT, ST_ON: begin
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_ON_AUX_MS)) aux_nxt = 1'b1; // RL4
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_ON_USB_MS)) usb_nxt = 1'b1; // RL5
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_ON_UART_MS)) uart_nxt = 1'b1; // RL3
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_ON_STATUS_MS)) begin
               status_nxt = 1'b1; // RL2 RL16
               st_nxt = ST_ON;
            end
            if (key_off || i_sw_shutdown || v_out || t_off) begin // RL12 RL13 RL14
               st_nxt = ST_DETACH;
               ms_nxt = '0;
               key_used_nxt = key_low ? 1'b1 : key_used_r;
            end
         end
         ST_DETACH, ST_DOWN: begin
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_DETACH_MS)) st_nxt = ST_DOWN; // RL15
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_OFF_UART_MS)) uart_nxt = 1'b0; // RL9
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_OFF_STATUS_MS)) status_nxt = 1'b0; // RL8 RL16
            if (ms_r >= mpks_pkg::MS_W'(mpks_pkg::T_OFF_USB_MS)) begin
               usb_nxt = 1'b0; // RL10
               aux_nxt = 1'b0;
               st_nxt = ST_OFF;
            end
         end
         default: st_nxt = ST_OFF;
      endcase
      if (rst_fire) begin
         st_nxt = ST_OFF;
         status_nxt = 1'b0;
         uart_nxt = 1'b0;
         usb_nxt = 1'b0;
         aux_nxt = 1'b0;
      end
      vwarn_nxt = warn_en_r && (i_volt < i_volt_lo || i_volt > i_volt_hi) && status_r;
      twarn_nxt = t_warn && status_r; // RL14
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         st_r <= ST_OFF;
         sub_r <= '0;
         ms_r <= '0;
         key_ms_r <= '0;
         rst_ms_r <= '0;
         key_used_r <= 1'b0;
         win_en_r <= 1'b0;
         warn_en_r <= 1'b0;
         status_r <= 1'b0;
         uart_r <= 1'b0;
         usb_r <= 1'b0;
         aux_r <= 1'b0;
         vwarn_r <= 1'b0;
         twarn_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         sub_r <= sub_nxt;
         ms_r <= ms_nxt;
         key_ms_r <= key_ms_nxt;
         rst_ms_r <= rst_ms_nxt;
         key_used_r <= key_used_nxt;
         win_en_r <= win_en_nxt;
         warn_en_r <= warn_en_nxt;
         status_r <= status_nxt;
         uart_r <= uart_nxt;
         usb_r <= usb_nxt;
         aux_r <= aux_nxt;
         vwarn_r <= vwarn_nxt;
         twarn_r <= twarn_nxt;
      end
   end
   assign bus.status = status_r;
   assign bus.uart_ready = uart_r;
   assign bus.usb_ready = usb_r;
   assign bus.aux_ready = aux_r;
   assign o_supply_warning = vwarn_r;
   assign o_temp_warning = twarn_r;
   assign o_fw_ready = status_r;
   assign o_safe_state = (st_r == ST_DOWN);
endmodule : mpks_device

//--- design/mpks_host.sv
`timescale 1ns/100ps
module mpks_host #(
   parameter int unsigned SCALE_MS = mpks_pkg::CLK_PER_MS
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   mpks_if.host bus,
   input wire logic i_power_on,
   input wire logic i_power_off,
   input wire logic i_emergency_reset,
   output logic o_busy,
   output logic o_status,
   output logic o_uart_ready,
   output logic o_usb_ready,
   output logic o_aux_ready
);
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_KEY = 2'b01,
      HS_RST = 2'b10
   } mpks_hstate_t;
   mpks_hstate_t st_r, st_nxt;
   logic [mpks_pkg::SUB_W-1:0] sub_r, sub_nxt;
   logic [mpks_pkg::MS_W-1:0] ms_r, ms_nxt, len_r, len_nxt;
   logic [3:0] s1_r, s2_r;
   logic tick;
   assign tick = (sub_r >= mpks_pkg::SUB_W'(SCALE_MS - 1));
   always_comb begin
      st_nxt = st_r;
      len_nxt = len_r;
      sub_nxt = tick ? '0 : sub_r + 1'b1;
      ms_nxt = tick ? ms_r + 1'b1 : ms_r;
      unique case (st_r)
         HS_IDLE: begin
            ms_nxt = '0;
            sub_nxt = '0;
            if (i_emergency_reset) begin // RL18
               st_nxt = HS_RST;
               len_nxt = mpks_pkg::MS_W'(mpks_pkg::T_RST_TYP_MS);
            end else if (i_power_off) begin
               st_nxt = HS_KEY;
               len_nxt = mpks_pkg::MS_W'(mpks_pkg::T_OFF_KEY_MS + 1); // RL7
            end else if (i_power_on) begin // RL11
               st_nxt = HS_KEY;
               len_nxt = mpks_pkg::MS_W'(mpks_pkg::T_ON_TYP_MS); // RL1
            end
         end
         HS_KEY, HS_RST: begin
            if (ms_r >= len_r) st_nxt = HS_IDLE; // RL17
         end
         default: st_nxt = HS_IDLE;
      endcase
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         st_r <= HS_IDLE;
         sub_r <= '0;
         ms_r <= '0;
         len_r <= '0;
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         st_r <= st_nxt;
         sub_r <= sub_nxt;
         ms_r <= ms_nxt;
         len_r <= len_nxt;
         s1_r <= {bus.status, bus.uart_ready, bus.usb_ready, bus.aux_ready};
         s2_r <= s1_r;
      end
   end
   assign bus.pwr_key_n_o = 1'b0;
   assign bus.pwr_key_n_oe_n = (st_r != HS_KEY);
   assign bus.reset_n_o = 1'b0;
   assign bus.reset_n_oe_n = (st_r != HS_RST);
   assign o_busy = (st_r != HS_IDLE);
   assign o_status = s2_r[3];
   assign o_uart_ready = s2_r[2];
   assign o_usb_ready = s2_r[1];
   assign o_aux_ready = s2_r[0];
endmodule : mpks_host

//--- verification/mpks_assertions.sv
`timescale 1ns/100ps
module mpks_assertions #(
   parameter int unsigned SCALE_MS = 1
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic pwr_key_n_o,
   input wire logic pwr_key_n_oe_n,
   input wire logic reset_n_o,
   input wire logic reset_n_oe_n,
   input wire logic status,
   input wire logic uart_ready,
   input wire logic usb_ready,
   input wire logic aux_ready
);
   localparam int unsigned AUX_MIN = 2500 * SCALE_MS;
   localparam int unsigned USB_MIN = 11000 * SCALE_MS;
   localparam int unsigned UART_MIN = 13000 * SCALE_MS;
   localparam int unsigned ON_MIN = 15000 * SCALE_MS;
   logic key_w;
   logic key_r, key_nxt;
   logic [31:0] since_r, since_nxt;
   // wire level of the key, pulled up when released
   assign key_w = pwr_key_n_oe_n | pwr_key_n_o;
   // cycles since the key was last pressed
   always_comb begin
      key_nxt = key_w;
      since_nxt = since_r;
      if (key_r && !key_w)
         since_nxt = 32'h0000_0000;
      else if (since_r != 32'hffff_ffff)
         since_nxt = since_r + 32'h0000_0001;
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         key_r <= 1'b1;
         since_r <= 32'h0000_0000;
      end else begin
         key_r <= key_nxt;
         since_r <= since_nxt;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   property p_status_rise;
      $rose(status) |-> uart_ready && usb_ready && aux_ready && since_r >= ON_MIN;
   endproperty
   a_status_rise: assert property (p_status_rise) else $error("status rose too early");
   property p_uart_rise;
      $rose(uart_ready) |-> usb_ready && aux_ready && !status && since_r >= UART_MIN;
   endproperty
   a_uart_rise: assert property (p_uart_rise) else $error("serial port ready out of order");
   property p_usb_rise;
      $rose(usb_ready) |-> aux_ready && !uart_ready && since_r >= USB_MIN;
   endproperty
   a_usb_rise: assert property (p_usb_rise) else $error("bus port ready out of order");
   property p_aux_rise;
      $rose(aux_ready) |-> !status && !uart_ready && !usb_ready && since_r >= AUX_MIN;
   endproperty
   a_aux_rise: assert property (p_aux_rise) else $error("aux supply ready out of order");
   property p_uart_fall;
      $fell(uart_ready) |-> status && usb_ready && aux_ready;
   endproperty
   a_uart_fall: assert property (p_uart_fall) else $error("serial port off out of order");
   property p_status_fall;
      $fell(status) |-> !uart_ready && usb_ready;
   endproperty
   a_status_fall: assert property (p_status_fall) else $error("status fell out of order");
   property p_usb_fall;
      $fell(usb_ready) |-> !status && !uart_ready && $fell(aux_ready);
   endproperty
   a_usb_fall: assert property (p_usb_fall) else $error("bus port off out of order");
   property p_reset_clear;
      $fell(i_sys_rst) |-> !status && !uart_ready && !usb_ready && !aux_ready;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs high after reset");
endmodule : mpks_assertions

//--- verification/testbench.sv
`timescale 1ns/100ps
module testbench;
   typedef struct {logic [3:0] v; int lo; int hi;} mpks_exp_t;
   localparam int unsigned SC = 1;
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic sw = 1'b0, wen = 1'b0, ven = 1'b0, cfg = 1'b0, pon = 1'b0, poff = 1'b0, erst = 1'b0;
   logic [mpks_pkg::VOLT_W-1:0] volt = 12'h0800;
   logic signed [mpks_pkg::TEMP_W-1:0] temp = 8'sh19;
   logic swarn, twarn, fwr, safe, busy;
   logic [3:0] hr;
   logic [3:0] prev = 4'h0;
   int n_fail = 0, check_count = 0, seed = 36938, cyc = 0, t0 = 0, el;
   mpks_exp_t q[$];
   mpks_exp_t e;
   mpks_if bus_if();
   wire [3:0] rdy = {bus_if.status, bus_if.uart_ready, bus_if.usb_ready, bus_if.aux_ready};
   mpks_device #(.SCALE_MS(SC)) mpks_device_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .bus(bus_if.device), .i_sw_shutdown(sw), .i_supply_window_en(wen), .i_supply_warning_en(ven),
      .i_cfg_valid(cfg), .i_volt(volt), .i_volt_lo(12'h0100), .i_volt_hi(12'h0e00), .i_temp(temp),
      .o_supply_warning(swarn), .o_temp_warning(twarn), .o_fw_ready(fwr), .o_safe_state(safe));
   mpks_host #(.SCALE_MS(SC)) mpks_host_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .bus(bus_if.host), .i_power_on(pon), .i_power_off(poff), .i_emergency_reset(erst), .o_busy(busy),
      .o_status(hr[3]), .o_uart_ready(hr[2]), .o_usb_ready(hr[1]), .o_aux_ready(hr[0]));
   mpks_assertions #(.SCALE_MS(SC)) mpks_assertions_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
      .pwr_key_n_o(bus_if.pwr_key_n_o), .pwr_key_n_oe_n(bus_if.pwr_key_n_oe_n), .reset_n_o(bus_if.reset_n_o),
      .reset_n_oe_n(bus_if.reset_n_oe_n), .status(bus_if.status), .uart_ready(bus_if.uart_ready),
      .usb_ready(bus_if.usb_ready), .aux_ready(bus_if.aux_ready));
   always #4 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) cyc <= cyc + 1;
   task automatic fail(input string m);
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail
   task chk(input logic [3:0] got, input logic [3:0] exp, input string m);
      check_count++;
      if (got !== exp) fail(m);
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic pulse(ref logic s);
      @(negedge i_sys_clk) s = 1'b1;
      t0 = cyc;
      @(negedge i_sys_clk) s = 1'b0;
   endtask : pulse
   task on_seq;
      q.push_back('{4'h1, 2500, 5100});
      q.push_back('{4'h3, 11000, 14600});
      q.push_back('{4'h7, 13000, 16600});
      q.push_back('{4'hf, 15000, 18600});
   endtask : on_seq
   task off_seq;
      q.push_back('{4'hb, 14000, 17600});
      q.push_back('{4'h3, 25000, 28600});
      q.push_back('{4'h0, 27000, 30600});
   endtask : off_seq
   task wait_q;
      for (int i = 0; i < 40000 && q.size() > 0; i++) @(negedge i_sys_clk);
      if (q.size() > 0) begin
         fail("ready sequence stalled");
         q.delete();
      end
   endtask : wait_q
   // ready lines checked in order and in time against the oldest note
   always @(negedge i_sys_clk) begin
      if (!i_sys_rst && rdy !== prev) begin
         prev = rdy;
         check_count++;
         if (q.size() == 0) begin
            fail("ready change without a pending note");
         end else begin
            e = q.pop_front();
            el = (cyc - t0) / SC;
            if (rdy !== e.v || el < e.lo || el > e.hi) fail("ready level or timing off");
         end
      end
   end
   initial begin
      repeat (99000) @(posedge i_sys_clk);
      fail("watchdog expired");
      end_sim();
   end
   initial begin
      repeat (16) @(negedge i_sys_clk);
      i_sys_rst = 1'b0;
      @(negedge i_sys_clk);
      chk(rdy, 4'h0, "outputs not low after reset");
      pulse(pon);
      chk({busy, 3'h0}, 4'h8, "host not busy during key pulse");
      on_seq();
      wait_q();
      repeat (4) @(negedge i_sys_clk);
      chk(hr, 4'hf, "host view of ready lines");
      chk({busy, 3'h0}, 4'h0, "host still busy after key pulse");
      chk({fwr, swarn, twarn, 1'b0}, 4'h8, "firmware ready flags");
      volt = {4'hf, 8'($random(seed))};
      temp = 8'sh51;
      repeat (8) @(negedge i_sys_clk);
      chk({rdy[3], swarn, twarn, 1'b0}, 4'ha, "warnings with supply checks disabled");
      temp = 8'sh19;
      {wen, ven, cfg} = 3'h7;
      t0 = cyc;
      @(negedge i_sys_clk) cfg = 1'b0;
      off_seq();
      repeat (1500) @(negedge i_sys_clk);
      chk({safe, swarn, 2'h0}, 4'hc, "safe state or supply warning missing");
      wait_q();
      volt = {4'h8, 8'($random(seed))};
      pulse(pon);
      on_seq();
      wait_q();
      volt = {4'hf, 8'($random(seed))};
      repeat (8) @(negedge i_sys_clk);
      chk({rdy[3], swarn, 2'h0}, 4'h8, "supply checks kept after power-on");
      pulse(poff);
      off_seq();
      wait_q();
      repeat (4) @(negedge i_sys_clk);
      chk(hr, 4'h0, "host view after power-off");
      pulse(pon);
      q.push_back('{4'h1, 2500, 5100});
      wait_q();
      temp = 8'sh56;
      repeat (1100) @(negedge i_sys_clk);
      chk({safe, 3'h0}, 4'h8, "no shutdown above temperature limit");
      temp = 8'sh19;
      pulse(erst);
      q.push_back('{4'h0, 100, 500});
      wait_q();
      pulse(pon);
      repeat (600) @(negedge i_sys_clk);
      pulse(sw);
      repeat (1100) @(negedge i_sys_clk);
      chk({safe, 3'h0}, 4'h8, "no shutdown on software command");
      pulse(erst);
      repeat (300) @(negedge i_sys_clk);
      chk({safe, rdy[2:0]}, 4'h0, "emergency reset did not clear state");
      end_sim();
   end
endmodule : testbench
